// file: rtl/boot_spi_loader.sv
// Serial boot loader: probe sequence and SPI slave code download
`timescale 1ns/100ps
module boot_spi_loader #(
	parameter int PROBE_IDLE_CYC = boot_pkg::PROBE_IDLE_CYC,
	parameter int RAM_WORDS = boot_pkg::RAM_WORDS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk_pad_in,
	output logic sclk_pad_out,
	output logic sclk_pad_oe,
	input wire logic cs_n_pad_in,
	output logic cs_n_pad_out,
	output logic cs_n_pad_oe,
	input wire logic mosi_pad_in,
	output logic mosi_pad_out,
	output logic mosi_pad_oe,
	output logic miso_pad_out,
	output logic miso_pad_oe,
	output logic pull_down_en,
	output logic [4:0] probe_step,
	output logic probe_uart,
	output logic alt_probe_req,
	input wire logic alt_probe_done,
	input wire logic alt_probe_found,
	output logic qspi_enable,
	input wire logic flash_check_done,
	input wire logic flash_image_ok,
	output logic run_flash,
	output logic debug_wait,
	output logic ram_we,
	output logic [31:0] ram_addr,
	output logic [31:0] ram_wdata,
	output logic [1:0] boot_remap_select,
	output logic sw_reset
);
	localparam int IW = $clog2(PROBE_IDLE_CYC);

	byte_link_if lnk ();

	boot_pkg::boot_state_e state_reg, state_next;
	boot_pkg::dl_phase_e phase_reg, phase_next;
	logic [4:0] step_reg, step_next;
	logic [3:0] slot_reg, slot_next;
	logic [15:0] len_reg, len_next;
	logic [7:0] crc_rx_reg, crc_rx_next;
	logic [7:0] crc_reg, crc_next;
	logic [1:0] mode_reg, mode_next;
	logic mode_bad_reg, mode_bad_next;
	logic pre_ok_reg, pre_ok_next;
	logic nack_reg, nack_next;
	logic [17:0] cnt_reg, cnt_next;
	logic [1:0] wpos_reg, wpos_next;
	logic [31:0] word_reg, word_next;
	logic [2:0] trail_reg, trail_next;
	logic [IW-1:0] idle_reg, idle_next;
	logic [7:0] tx_reg, tx_next;
	logic start_reg, start_next;
	logic we_reg, we_next;
	logic [31:0] addr_reg, addr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [1:0] remap_reg, remap_next;
	logic swrst_reg, swrst_next;
	logic [10:0] pad_reg, pad_next;
	logic [4:0] misc_reg, misc_next;
	logic fail;
	logic [2:0] wbytes;
	logic [1:0] bpos;
	logic id_done, id_sclk, id_cs_n, id_mosi, slv_miso;

	spi_id_sender u_id (
		.clk(clk),
		.reset(reset),
		.start(start_reg),
		.done(id_done),
		.sclk(id_sclk),
		.cs_n(id_cs_n),
		.mosi(id_mosi)
	);

	spi_slave_shifter u_shift (
		.clk(clk),
		.reset(reset),
		.sclk_pad(sclk_pad_in),
		.cs_n_pad(cs_n_pad_in),
		.mosi_pad(mosi_pad_in),
		.lnk(lnk),
		.miso(slv_miso)
	);

	assign lnk.enable = (state_reg == boot_pkg::ST_SLAVE);
	assign lnk.tx_data = tx_reg;
	assign wbytes = 3'h1 << mode_reg; // Bytes per payload slot
	// Arrival order within a slot is high byte first
	assign bpos = wpos_reg ^ 2'(wbytes - 3'h1);

	// Probe sequencing and download protocol
	always_comb
	begin
		state_next = state_reg;
		phase_next = phase_reg;
		step_next = step_reg;
		slot_next = slot_reg;
		len_next = len_reg;
		crc_rx_next = crc_rx_reg;
		crc_next = crc_reg;
		mode_next = mode_reg;
		mode_bad_next = mode_bad_reg;
		pre_ok_next = pre_ok_reg;
		nack_next = nack_reg;
		cnt_next = cnt_reg;
		wpos_next = wpos_reg;
		word_next = word_reg;
		trail_next = trail_reg;
		idle_next = idle_reg;
		tx_next = tx_reg;
		start_next = 1'b0;
		we_next = 1'b0;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		remap_next = remap_reg;
		swrst_next = 1'b0;
		fail = 1'b0;
		case (state_reg)
			boot_pkg::ST_START:
			begin
				start_next = 1'b1;
				phase_next = boot_pkg::PH_HDR;
				slot_next = 4'h0;
				crc_next = boot_pkg::CRC_SEED;
				nack_next = 1'b0;
				pre_ok_next = 1'b0;
				cnt_next = 18'h00000;
				wpos_next = 2'h0;
				idle_next = '0;
				tx_next = boot_pkg::EMPTY_BYTE;
				state_next = boot_pkg::ST_ID_SEND;
			end
			boot_pkg::ST_ID_SEND:
				if (id_done)
					state_next = boot_pkg::ST_SLAVE;
			boot_pkg::ST_SLAVE:
			begin
				// A silent master ends the attempt after the idle limit
				idle_next = idle_reg + 1'b1;
				if (idle_reg == IW'(PROBE_IDLE_CYC - 1))
					fail = 1'b1;
				if (lnk.rx_valid)
				begin
					idle_next = '0;
					tx_next = boot_pkg::EMPTY_BYTE;
					if (nack_reg)
						fail = 1'b1;
					else
						case (phase_reg)
							boot_pkg::PH_HDR:
							begin
								slot_next = slot_reg + 4'h1;
								case (slot_reg)
									boot_pkg::SLOT_PRE0:
										pre_ok_next = (lnk.rx_data == boot_pkg::PRE_BYTE0);
									boot_pkg::SLOT_PRE1:
										pre_ok_next = pre_ok_reg &&
											(lnk.rx_data == boot_pkg::PRE_BYTE1);
									boot_pkg::SLOT_EMPTY:
									begin
										if (pre_ok_reg && lnk.rx_data == boot_pkg::EMPTY_BYTE)
											tx_next = boot_pkg::ACK_BYTE;
										else
										begin
											tx_next = boot_pkg::NACK_BYTE;
											nack_next = 1'b1;
										end
									end
									boot_pkg::SLOT_LEN_LO:
										len_next[7:0] = lnk.rx_data;
									boot_pkg::SLOT_LEN_HI:
										len_next[15:8] = lnk.rx_data;
									boot_pkg::SLOT_CRC:
									begin
										crc_rx_next = lnk.rx_data;
										if (len_reg != 16'h0000 &&
											32'(len_reg) <= 32'(RAM_WORDS))
											tx_next = boot_pkg::ACK_BYTE;
										else
										begin
											tx_next = boot_pkg::NACK_BYTE;
											nack_next = 1'b1;
										end
									end
									boot_pkg::SLOT_MODE:
									begin
										mode_next = lnk.rx_data[1:0];
										mode_bad_next = lnk.rx_data > boot_pkg::MODE_LAST;
									end
									boot_pkg::SLOT_ZERO:
									begin
										phase_next = boot_pkg::PH_DATA;
										if (!mode_bad_reg)
											tx_next = boot_pkg::ACK_BYTE;
										else
										begin
											tx_next = boot_pkg::NACK_BYTE;
											nack_next = 1'b1;
										end
									end
									default:
										slot_next = slot_reg;
								endcase
							end
							boot_pkg::PH_DATA:
							begin
								crc_next = crc_reg ^ lnk.rx_data;
								word_next[{bpos, 3'b000} +: 8] = lnk.rx_data;
								wpos_next = wpos_reg + 2'h1;
								cnt_next = cnt_reg + 18'h00001;
								if (wpos_reg == 2'h3)
								begin
									// Word complete: lowest byte came first only with 8-bit slots
									we_next = 1'b1;
									addr_next = boot_pkg::RAM_BASE +
										{14'h0000, cnt_reg[17:2], 2'b00};
									wdata_next = word_next;
								end
								if (cnt_reg == {len_reg, 2'b00} - 18'h00001)
								begin
									phase_next = boot_pkg::PH_TRAIL;
									trail_next = 3'h0;
									tx_next = boot_pkg::FILL_BYTE;
								end
							end
							boot_pkg::PH_TRAIL:
							begin
								trail_next = trail_reg + 3'h1;
								if (trail_reg + 3'h1 < wbytes)
									tx_next = boot_pkg::FILL_BYTE;
								else if (crc_reg == crc_rx_reg)
									tx_next = boot_pkg::ACK_BYTE;
								else
									tx_next = boot_pkg::NACK_BYTE;
								if (trail_reg == 3'((wbytes << 1) - 3'h1))
								begin
									if (crc_reg == crc_rx_reg)
										state_next = boot_pkg::ST_REMAP;
									else
										fail = 1'b1;
								end
							end
							default:
								phase_next = boot_pkg::PH_HDR;
						endcase
				end
				// Failed attempt: repeat once, then hand over to other probes
				if (fail)
				begin
					if (step_reg == boot_pkg::FIRST_STEP)
					begin
						step_next = boot_pkg::SECOND_STEP;
						state_next = boot_pkg::ST_START;
					end
					else
					begin
						step_next = boot_pkg::FIRST_ALT_STEP;
						state_next = boot_pkg::ST_ALT;
					end
				end
			end
			boot_pkg::ST_ALT:
				if (alt_probe_done)
				begin
					if (alt_probe_found)
						state_next = boot_pkg::ST_HANDOFF;
					else if (step_reg == boot_pkg::LAST_STEP)
						state_next = boot_pkg::ST_FLASH;
					else
						step_next = step_reg + 5'h01;
				end
			boot_pkg::ST_FLASH:
				if (flash_check_done)
					state_next = flash_image_ok ? boot_pkg::ST_RUN :
						boot_pkg::ST_DEBUG;
			boot_pkg::ST_REMAP:
			begin
				remap_next = boot_pkg::REMAP_RAM;
				state_next = boot_pkg::ST_RESET;
			end
			boot_pkg::ST_RESET:
			begin
				swrst_next = 1'b1;
				state_next = boot_pkg::ST_HANDOFF;
			end
			boot_pkg::ST_RUN, boot_pkg::ST_DEBUG, boot_pkg::ST_HANDOFF:
				state_next = state_reg;
			default:
				state_next = boot_pkg::ST_START;
		endcase
	end

	// Pads follow the role; registered so every pin comes from a flop
	always_comb
	begin
		pad_next = 11'h000;
		misc_next = 5'h00;
		case (state_next)
			boot_pkg::ST_ID_SEND:
				pad_next = {id_sclk, 1'b1, id_cs_n, 1'b1, id_mosi, 1'b1,
					4'h0, 1'b0};
			boot_pkg::ST_SLAVE:
				pad_next = {6'h00, slv_miso, 1'b1, 3'h0};
			default:
				pad_next = {10'h000, 1'b1};
		endcase
		misc_next = {state_next == boot_pkg::ST_ALT,
			state_next == boot_pkg::ST_FLASH ||
			state_next == boot_pkg::ST_RUN,
			state_next == boot_pkg::ST_RUN,
			state_next == boot_pkg::ST_DEBUG,
			step_next <= boot_pkg::LAST_UART_STEP};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_reg <= boot_pkg::ST_START;
			phase_reg <= boot_pkg::PH_HDR;
			step_reg <= boot_pkg::FIRST_STEP;
			slot_reg <= 4'h0;
			len_reg <= 16'h0000;
			crc_rx_reg <= 8'h00;
			crc_reg <= boot_pkg::CRC_SEED;
			mode_reg <= 2'h0;
			mode_bad_reg <= 1'b0;
			pre_ok_reg <= 1'b0;
			nack_reg <= 1'b0;
			cnt_reg <= 18'h00000;
			wpos_reg <= 2'h0;
			word_reg <= 32'h00000000;
			trail_reg <= 3'h0;
			idle_reg <= '0;
			tx_reg <= 8'h00;
			start_reg <= 1'b0;
			we_reg <= 1'b0;
			addr_reg <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			remap_reg <= 2'h0;
			swrst_reg <= 1'b0;
			pad_reg <= 11'h001;
			misc_reg <= 5'h01;
		end
		else
		begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			step_reg <= step_next;
			slot_reg <= slot_next;
			len_reg <= len_next;
			crc_rx_reg <= crc_rx_next;
			crc_reg <= crc_next;
			mode_reg <= mode_next;
			mode_bad_reg <= mode_bad_next;
			pre_ok_reg <= pre_ok_next;
			nack_reg <= nack_next;
			cnt_reg <= cnt_next;
			wpos_reg <= wpos_next;
			word_reg <= word_next;
			trail_reg <= trail_next;
			idle_reg <= idle_next;
			tx_reg <= tx_next;
			start_reg <= start_next;
			we_reg <= we_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			remap_reg <= remap_next;
			swrst_reg <= swrst_next;
			pad_reg <= pad_next;
			misc_reg <= misc_next;
		end
	end

	assign sclk_pad_out = pad_reg[10];
	assign sclk_pad_oe = pad_reg[9];
	assign cs_n_pad_out = pad_reg[8];
	assign cs_n_pad_oe = pad_reg[7];
	assign mosi_pad_out = pad_reg[6];
	assign mosi_pad_oe = pad_reg[5];
	assign miso_pad_out = pad_reg[4];
	assign miso_pad_oe = pad_reg[3];
	assign pull_down_en = pad_reg[0];
	assign alt_probe_req = misc_reg[4];
	assign qspi_enable = misc_reg[3];
	assign run_flash = misc_reg[2];
	assign debug_wait = misc_reg[1];
	assign probe_uart = misc_reg[0];
	assign probe_step = step_reg;
	assign ram_we = we_reg;
	assign ram_addr = addr_reg;
	assign ram_wdata = wdata_reg;
	assign boot_remap_select = remap_reg;
	assign sw_reset = swrst_reg;
endmodule : boot_spi_loader

// file: inc/boot_pkg.sv
// Shared constants and types for the serial boot loader
package boot_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int SCLK_HZ = 4_000_000;
	localparam int SCLK_HALF_CYC = CLK_HZ / (2 * SCLK_HZ);
	localparam int PROBE_IDLE_US = 10_000;
	localparam int PROBE_IDLE_CYC = (CLK_HZ / 1_000_000) * PROBE_IDLE_US;
	localparam int ID_LEN = 10;
	localparam logic [79:0] ID_TEXT = "LOADER0001";
	localparam logic [7:0] PRE_BYTE0 = 8'h70;
	localparam logic [7:0] PRE_BYTE1 = 8'h50;
	localparam logic [7:0] EMPTY_BYTE = 8'h00;
	localparam logic [7:0] ACK_BYTE = 8'h02;
	localparam logic [7:0] NACK_BYTE = 8'h20;
	localparam logic [7:0] FILL_BYTE = 8'hAA;
	localparam logic [7:0] CRC_SEED = 8'hFF;
	localparam logic [7:0] MODE_LAST = 8'h02;
	localparam logic [3:0] SLOT_PRE0 = 4'h0;
	localparam logic [3:0] SLOT_PRE1 = 4'h1;
	localparam logic [3:0] SLOT_EMPTY = 4'h2;
	localparam logic [3:0] SLOT_LEN_LO = 4'h3;
	localparam logic [3:0] SLOT_LEN_HI = 4'h4;
	localparam logic [3:0] SLOT_CRC = 4'h5;
	localparam logic [3:0] SLOT_MODE = 4'h6;
	localparam logic [3:0] SLOT_ZERO = 4'h7;
	localparam logic [31:0] RAM_BASE = 32'h07FC0000;
	localparam int RAM_WORDS = 16384;
	localparam logic [1:0] REMAP_RAM = 2'h3;
	localparam logic [4:0] FIRST_STEP = 5'h01;
	localparam logic [4:0] SECOND_STEP = 5'h02;
	localparam logic [4:0] FIRST_ALT_STEP = 5'h03;
	localparam logic [4:0] LAST_UART_STEP = 5'h0C;
	localparam logic [4:0] LAST_STEP = 5'h16;

	typedef enum logic [3:0] {
		ST_START = 4'h0,
		ST_ID_SEND = 4'h1,
		ST_SLAVE = 4'h2,
		ST_ALT = 4'h3,
		ST_FLASH = 4'h4,
		ST_RUN = 4'h5,
		ST_DEBUG = 4'h6,
		ST_REMAP = 4'h7,
		ST_RESET = 4'h8,
		ST_HANDOFF = 4'h9
	} boot_state_e;

	typedef enum logic [1:0] {
		PH_HDR = 2'h0,
		PH_DATA = 2'h1,
		PH_TRAIL = 2'h2
	} dl_phase_e;
endpackage : boot_pkg

// file: inc/byte_link_if.sv
// Byte exchange between the loader core and the slave shifter
`timescale 1ns/100ps
interface byte_link_if;
	logic enable;
	logic rx_valid;
	logic [7:0] rx_data;
	logic [7:0] tx_data;
	modport core (output enable, output tx_data, input rx_valid,
		input rx_data);
	modport shifter (input enable, input tx_data, output rx_valid,
		output rx_data);
endinterface : byte_link_if

// file: rtl/spi_id_sender.sv
// Master-role sender of the identification text, mode 0, 8-bit frames
`timescale 1ns/100ps
module spi_id_sender #(
	parameter int ID_LEN = boot_pkg::ID_LEN,
	parameter logic [8*ID_LEN-1:0] ID_TEXT = boot_pkg::ID_TEXT,
	parameter int HALF = boot_pkg::SCLK_HALF_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	output logic done,
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	localparam int TOTAL = 2 * 8 * ID_LEN;
	localparam int BW = $clog2(TOTAL);
	localparam int DW = $clog2(HALF + 1);

	logic active_reg, active_next;
	logic sclk_reg, sclk_next;
	logic done_reg, done_next;
	logic [DW-1:0] div_reg, div_next;
	logic [BW-1:0] bit_reg, bit_next;
	int char_idx;

	// Divider and bit walk; text goes out twice with no separator
	always_comb
	begin
		active_next = active_reg;
		sclk_next = sclk_reg;
		div_next = div_reg;
		bit_next = bit_reg;
		done_next = 1'b0;
		if (!active_reg)
		begin
			if (start)
			begin
				active_next = 1'b1;
				div_next = '0;
				sclk_next = 1'b0;
				bit_next = '0;
			end
		end
		else if (div_reg == DW'(HALF - 1))
		begin
			div_next = '0;
			sclk_next = !sclk_reg; // Idles low, data set before rise
			if (sclk_reg)
			begin
				if (bit_reg == BW'(TOTAL - 1))
				begin
					active_next = 1'b0;
					done_next = 1'b1;
				end
				else
					bit_next = bit_reg + 1'b1;
			end
		end
		else
			div_next = div_reg + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			active_reg <= 1'b0;
			sclk_reg <= 1'b0;
			div_reg <= '0;
			bit_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			active_reg <= active_next;
			sclk_reg <= sclk_next;
			div_reg <= div_next;
			bit_reg <= bit_next;
			done_reg <= done_next;
		end
	end

	// Second copy reuses the text by wrapping the character index
	always_comb
	begin
		char_idx = int'(bit_reg[BW-1:3]) % ID_LEN;
		mosi = active_reg &&
			ID_TEXT[8 * (ID_LEN - 1 - char_idx) + 7 - int'(bit_reg[2:0])];
	end

	assign sclk = sclk_reg;
	assign cs_n = !active_reg;
	assign done = done_reg;
endmodule : spi_id_sender

// file: rtl/spi_slave_shifter.sv
// Mode 0 byte shifter for the slave role, pins synchronised here
`timescale 1ns/100ps
module spi_slave_shifter (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk_pad,
	input wire logic cs_n_pad,
	input wire logic mosi_pad,
	byte_link_if.shifter lnk,
	output logic miso
);
	logic [2:0] sync1_reg, sync2_reg;
	logic sclk_prev_reg;
	logic [7:0] rx_sh_reg, rx_sh_next;
	logic [7:0] tx_sh_reg, tx_sh_next;
	logic [7:0] rx_data_reg, rx_data_next;
	logic [2:0] bit_reg, bit_next;
	logic valid_reg, valid_next;
	logic load_reg, load_next;
	logic rise, fall;

	// Two flops per pin; only the second stage feeds logic
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			// Idle levels: deselected, clock low, so no false edge
			sync1_reg <= 3'h4;
			sync2_reg <= 3'h4;
			sclk_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= {cs_n_pad, mosi_pad, sclk_pad};
			sync2_reg <= sync1_reg;
			sclk_prev_reg <= sync2_reg[0];
		end
	end

	assign rise = sync2_reg[0] && !sclk_prev_reg;
	assign fall = !sync2_reg[0] && sclk_prev_reg;

	// Sample on rise, shift out on fall; reload once the core has answered
	always_comb
	begin
		rx_sh_next = rx_sh_reg;
		tx_sh_next = tx_sh_reg;
		rx_data_next = rx_data_reg;
		bit_next = bit_reg;
		valid_next = 1'b0;
		load_next = valid_reg; // Core answer is registered after valid
		if (!lnk.enable || sync2_reg[2])
		begin
			bit_next = 3'h0;
			tx_sh_next = lnk.tx_data;
		end
		else
		begin
			if (rise)
			begin
				rx_sh_next = {rx_sh_reg[6:0], sync2_reg[1]};
				bit_next = bit_reg + 3'h1;
				if (bit_reg == 3'h7)
				begin
					rx_data_next = {rx_sh_reg[6:0], sync2_reg[1]};
					valid_next = 1'b1;
				end
			end
			// No shift on the fall that closes a byte: bit count is zero
			if (fall && bit_reg != 3'h0)
				tx_sh_next = {tx_sh_reg[6:0], 1'b0};
			if (load_reg)
				tx_sh_next = lnk.tx_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_sh_reg <= 8'h00;
			tx_sh_reg <= 8'h00;
			rx_data_reg <= 8'h00;
			bit_reg <= 3'h0;
			valid_reg <= 1'b0;
			load_reg <= 1'b0;
		end
		else
		begin
			rx_sh_reg <= rx_sh_next;
			tx_sh_reg <= tx_sh_next;
			rx_data_reg <= rx_data_next;
			bit_reg <= bit_next;
			valid_reg <= valid_next;
			load_reg <= load_next;
		end
	end

	assign lnk.rx_valid = valid_reg;
	assign lnk.rx_data = rx_data_reg;
	assign miso = tx_sh_reg[7];
endmodule : spi_slave_shifter

// file: verification/boot_spi_loader_monitor.sv
// Port-level assertions for the serial boot loader
`timescale 1ns/100ps
module boot_spi_loader_monitor #(
	parameter int PROBE_IDLE_CYC = boot_pkg::PROBE_IDLE_CYC,
	parameter int RAM_WORDS = boot_pkg::RAM_WORDS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk_pad_out,
	input wire logic sclk_pad_oe,
	input wire logic cs_n_pad_oe,
	input wire logic mosi_pad_oe,
	input wire logic miso_pad_oe,
	input wire logic pull_down_en,
	input wire logic [4:0] probe_step,
	input wire logic probe_uart,
	input wire logic alt_probe_req,
	input wire logic qspi_enable,
	input wire logic run_flash,
	input wire logic debug_wait,
	input wire logic ram_we,
	input wire logic [31:0] ram_addr,
	input wire logic [1:0] boot_remap_select,
	input wire logic sw_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Master clock: five system cycles high per half period
	chk_sclk_half: assert property ($rose(sclk_pad_out)
		&& sclk_pad_oe |-> sclk_pad_out [*5] ##1 !sclk_pad_out)
		else $error("serial clock high time wrong");
	chk_pads_free: assert property (pull_down_en |-> !(sclk_pad_oe
		|| cs_n_pad_oe || mosi_pad_oe || miso_pad_oe))
		else $error("pad driven while released");
	// Steps only ever advance by one
	chk_step_order: assert property ($changed(probe_step) |->
		probe_step == $past(probe_step) + 5'h01)
		else $error("probe step skipped");
	// Flag is registered from the next step, so it changes with it; test when settled
	chk_uart_flag: assert property ($stable(probe_step) |->
		probe_uart == (probe_step <= 5'h0C))
		else $error("uart flag wrong");
	chk_alt_range: assert property (alt_probe_req |->
		probe_step >= 5'h03 && probe_step <= 5'h16)
		else $error("alternate probe outside steps");
	chk_flash_after: assert property ($rose(qspi_enable) |->
		probe_step == 5'h16)
		else $error("flash check before last step");
	chk_debug_end: assert property ($rose(debug_wait) |->
		!run_flash && $past(qspi_enable))
		else $error("debug idle without flash check");
	chk_remap_first: assert property (sw_reset |->
		$past(boot_remap_select) == 2'h3 ##1 !sw_reset)
		else $error("reset before remap");
	chk_ram_range: assert property (ram_we |-> ram_addr[1:0] == 2'h0
		&& ram_addr >= 32'h07FC0000
		&& ram_addr < 32'h07FC0000 + 4 * RAM_WORDS)
		else $error("ram write outside system ram");
endmodule : boot_spi_loader_monitor

bind boot_spi_loader boot_spi_loader_monitor #(
	.PROBE_IDLE_CYC(PROBE_IDLE_CYC),
	.RAM_WORDS(RAM_WORDS)
) mon (.*);

// file: verification/spi_host_model.sv
// Host microcontroller model: SPI master, mode 0, one byte per call
`timescale 1ns/100ps
module spi_host_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	// Clock idles low, select high between bytes
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// 200 ns clock is above the continuous limit, so pause per byte
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			cs_n = 1'b0;
			mosi = tx[i];
			#100 sclk = 1'b1;
			#95 rx[i] = miso; // Late sample: answer lags the edge
			#5 sclk = 1'b0;
		end
		#50 mosi = ~mosi; // No stale bit once released
		#150 cs_n = 1'b1;
		#200;
	endtask : xfer
endmodule : spi_host_model

// file: verification/serial_boot_spi_download_tb_top.sv
// Self-checking bench: download, refused preamble, full probe walk
`timescale 1ns/100ps
module serial_boot_spi_download_tb_top;
`define CHK(s, e, g) begin compares++; if ((g) !== (e)) begin \
	err_total++; $display("BAD %s exp %h got %h", s, e, g); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 6000) begin \
	@(negedge clk); n++; end if (n >= 6000) begin err_total++; \
	report_and_stop; end end
	typedef struct packed { logic [7:0] tx; logic [7:0] rx; } row_s;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic alt_probe_done = 1'b0;
	logic alt_probe_found = 1'b0;
	logic flash_check_done = 1'b0;
	logic flash_image_ok = 1'b0;
	logic sclk_pad_in, sclk_pad_out, sclk_pad_oe, cs_n_pad_in;
	logic cs_n_pad_out, cs_n_pad_oe, mosi_pad_in, mosi_pad_out;
	logic mosi_pad_oe, miso_pad_out, miso_pad_oe, pull_down_en;
	logic probe_uart, alt_probe_req, qspi_enable, run_flash;
	logic debug_wait, ram_we, sw_reset, h_sclk, h_cs_n, h_mosi;
	logic [4:0] probe_step;
	logic [1:0] boot_remap_select;
	logic [31:0] ram_addr, ram_wdata, w_addr, w_data;
	logic [159:0] id_seen;
	logic [7:0] rx;
	int err_total = 0;
	int compares = 0;
	int n;
	int wr_cnt = 0;
	int swrst_cnt = 0;
	// Host byte beside expected answer; one word in 8-bit slots
	row_s rows [14] = '{16'h7000, 16'h5000, 16'h0000,
		16'h0102, 16'h0000, 16'hBB00, 16'h0002,
		16'h0000, 16'h1102, 16'h2200, 16'h3300,
		16'h4400, 16'h00AA, 16'h0002};
	// Same word in 32-bit slots: high byte first, eight trailer bytes
	row_s rows_w [20] = '{16'h7000, 16'h5000, 16'h0000, 16'h0102,
		16'h0000, 16'hBB00, 16'h0202, 16'h0000,
		16'h4402, 16'h3300, 16'h2200, 16'h1100,
		16'h00AA, 16'h00AA, 16'h00AA, 16'h00AA,
		16'h0002, 16'h0002, 16'h0002, 16'h0002};

	// Pad levels: driver wins, else host, answer line pulled down
	wire miso_w = miso_pad_oe ? miso_pad_out : 1'b0;
	assign sclk_pad_in = sclk_pad_oe ? sclk_pad_out : h_sclk;
	assign cs_n_pad_in = cs_n_pad_oe ? cs_n_pad_out : h_cs_n;
	assign mosi_pad_in = mosi_pad_oe ? mosi_pad_out : h_mosi;

	boot_spi_loader #(.PROBE_IDLE_CYC(2000)) uut (.*);
	spi_host_model host (.sclk(h_sclk), .cs_n(h_cs_n), .mosi(h_mosi),
		.miso(miso_w));

	always #12.5 clk = ~clk;

	// Capture identification bits and RAM writes
	always @(posedge sclk_pad_out)
		if (sclk_pad_oe === 1'b1)
			id_seen <= {id_seen[158:0], mosi_pad_out};
	// Pulses are counted: they may fall inside a host transfer
	always @(posedge clk)
	begin
		if (ram_we === 1'b1)
		begin
			w_addr <= ram_addr;
			w_data <= ram_wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (sw_reset === 1'b1)
			swrst_cnt <= swrst_cnt + 1;
	end

	task automatic report_and_stop;
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// Reset held six cycles, then wait for the slave role
	task automatic restart;
		@(posedge clk) reset <= 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		`WAITC(miso_pad_oe === 1'b1)
		`CHK("remap0", 2'h0, boot_remap_select)
		`CHK("step1", 5'h01, probe_step)
	endtask : restart

	// Unanswered alternate steps walk to the end, then the flash check
	task automatic walk(input logic img);
		`WAITC(alt_probe_req === 1'b1)
		for (int s = 3; s <= 22; s++)
		begin
			`CHK("step", s[4:0], probe_step)
			`CHK("uart", s <= 12, probe_uart)
			@(posedge clk) alt_probe_done <= 1'b1;
			@(posedge clk) alt_probe_done <= 1'b0;
			repeat (3) @(negedge clk);
		end
		`WAITC(qspi_enable === 1'b1)
		@(posedge clk)
		begin
			flash_check_done <= 1'b1;
			flash_image_ok <= img;
		end
		@(posedge clk) flash_check_done <= 1'b0;
		`WAITC(run_flash === img && debug_wait === !img)
		`CHK("run", img, run_flash)
		`CHK("debug", !img, debug_wait)
	endtask : walk

	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		`WAITC(miso_pad_oe === 1'b1)
		`CHK("id", {boot_pkg::ID_TEXT, boot_pkg::ID_TEXT}, id_seen)
		foreach (rows[i])
		begin
			host.xfer(rows[i].tx, rx);
			`CHK("miso", rows[i].rx, rx)
		end
		`WAITC(swrst_cnt == 1)
		`CHK("remap", 2'h3, boot_remap_select)
		`CHK("addr", 32'h07FC0000, w_addr)
		`CHK("word", 32'h44332211, w_data)
		`CHK("writes", 1, wr_cnt)
		repeat (2) @(negedge clk);
		`CHK("pads", 1'b1, pull_down_en)
		// Second reset mid-run, a refused preamble, then a silent master
		restart;
		host.xfer(8'h71, rx);
		host.xfer(8'h50, rx);
		host.xfer(8'h00, rx);
		host.xfer(8'h00, rx);
		`CHK("nack", 8'h20, rx)
		`WAITC(probe_step === 5'h02)
		walk(1'b0);
		// Reserved width refused at step one, word-wide load at step two
		restart;
		for (int i = 0; i < 6; i++)
			host.xfer(rows[i].tx, rx);
		host.xfer(8'h03, rx);
		host.xfer(8'h00, rx);
		host.xfer(8'h44, rx);
		`CHK("mode nack", 8'h20, rx)
		`WAITC(probe_step === 5'h02)
		`WAITC(miso_pad_oe === 1'b1)
		foreach (rows_w[i])
		begin
			host.xfer(rows_w[i].tx, rx);
			`CHK("miso32", rows_w[i].rx, rx)
		end
		`WAITC(swrst_cnt == 2)
		`CHK("word32", 32'h44332211, w_data)
		`CHK("addr32", 32'h07FC0000, w_addr)
		`CHK("writes32", 2, wr_cnt)
		// Both listens silent, no alternate party, valid flash image
		restart;
		`WAITC(probe_step === 5'h02)
		walk(1'b1);
		report_and_stop;
	end
endmodule : serial_boot_spi_download_tb_top
